// ---- core/bpsd_pkg.sv ----
// Package of constants for the bridge output, polarity and shutdown block
package bpsd_pkg;
  // Register addresses on the plain port
  localparam logic [1:0] ADDR_MODULE_CTRL   = 2'h0; // Mode and polarity
  localparam logic [1:0] ADDR_SHUTDOWN_CTRL = 2'h1; // Shutdown control
  localparam logic [1:0] ADDR_PWM_CTRL      = 2'h2; // Auto-restart enable
  localparam logic [1:0] ADDR_STATUS        = 2'h3; // Live state readback
  // Module control fields
  localparam int MC_POL_AC   = 0; // Polarity of pair A/C, 1 = active low
  localparam int MC_POL_BD   = 1; // Polarity of pair B/D, 1 = active low
  localparam int MC_FULL     = 6; // Full-bridge enable
  localparam int MC_DIR      = 7; // Direction select, 1 = reverse
  // Shutdown control and PWM control fields
  localparam int SD_STATUS   = 7; // Shutdown event status
  localparam int SD_SRC_LSB  = 4; // Source select low bit
  localparam int SD_AC_LSB   = 2; // Pair A/C state low bit
  localparam int SD_BD_LSB   = 0; // Pair B/D state low bit
  localparam int PC_RESTART  = 7; // Auto-restart enable
  // Reset values
  localparam logic [7:0] RST_MODULE_CTRL   = 8'h00; // Cleared at reset
  localparam logic [7:0] RST_SHUTDOWN_CTRL = 8'h00; // Cleared at reset
  localparam logic [7:0] RST_PWM_CTRL      = 8'h00; // Cleared at reset
  // Source select codes
  localparam logic [2:0] SRC_OFF = 3'h0; // Auto-shutdown disabled
  // Shutdown pair states
  localparam logic [1:0] SS_LOW  = 2'h0; // Drive low
  localparam logic [1:0] SS_HIGH = 2'h1; // Drive high
  // Timing
  localparam int OSC_PER_CLK = 4; // Oscillator periods per clock (Fosc/4)
  localparam int PRESCALE    = 4; // Period timer prescale value
  localparam int LEAD_CYCLES = (PRESCALE + OSC_PER_CLK - 1) / OSC_PER_CLK; // Early swap
  // Run state
  typedef enum logic [2:0] {
    BPSD_IDLE = 3'b001, // Outputs inactive, awaiting period
    BPSD_RUN  = 3'b010, // Normal modulation
    BPSD_SHUT = 3'b100  // Shutdown forced
  } bpsd_state_t;
endpackage : bpsd_pkg

// ---- core/bpsd_core.sv ----
// Full-bridge direction, polarity and auto-shutdown output control
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module bpsd_core (
  input  wire logic       clk,          // 50 MHz clock
  input  wire logic       rst,          // Synchronous reset, active high
  input  wire logic [1:0] addr,         // Register address
  input  wire logic [7:0] wdata,        // Write data
  input  wire logic       wr,           // Write strobe
  input  wire logic       rd,           // Read strobe
  output logic      [7:0] rdata,        // Read data, one cycle later
  input  wire logic       period_start, // Period begins, one-cycle pulse
  input  wire logic       pwm_mod,      // Modulated waveform, active high
  input  wire logic       ext_int_pin,  // Interrupt pin, asynchronous
  input  wire logic       cmp1_out,     // Comparator 1, asynchronous
  input  wire logic       cmp2_out,     // Comparator 2, asynchronous
  output logic      [3:0] out_o,        // Pins D,C,B,A
  output logic      [3:0] out_oe,       // Pin enables D,C,B,A
  output logic            period_timer_flag // Sticky flag, set at second period
);
  // Registers
  logic [7:0] mc_q, mc_d;       // Module control
  logic [7:0] sd_q, sd_d;       // Shutdown control
  logic [7:0] pc_q, pc_d;       // PWM control
  logic [7:0] rdata_d;          // Read data next
  logic       dir_q, dir_d;     // Direction latched at boundary
  logic       flag_d;           // Period flag next
  logic [1:0] per_cnt_q, per_cnt_d; // Periods since enable, saturating
  logic [7:0] lead_q, lead_d;   // Cycles since period start
  logic [7:0] plen_q, plen_d;   // Measured period length
  bpsd_pkg::bpsd_state_t st_q, st_d; // Run state
  // Three-flop input synchronisers
  logic [2:0] s_int, s_c1, s_c2; // Sync chains
  logic       int_lvl_q, c1_lvl_q, c2_lvl_q; // Agreed levels
  logic       cond;             // Selected shutdown level
  logic [2:0] src;              // Source select
  logic       full, pend, lead; // Mode, pending reversal, early window
  logic       sw_shut;          // Software shutdown write this cycle

  // Synchronise pins; level changes once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s_int <= 3'h7; s_c1 <= 3'h0; s_c2 <= 3'h0;
      int_lvl_q <= 1'b1; c1_lvl_q <= 1'b0; c2_lvl_q <= 1'b0;
    end else begin
      s_int <= {s_int[1:0], ext_int_pin};
      s_c1  <= {s_c1[1:0], cmp1_out};
      s_c2  <= {s_c2[1:0], cmp2_out};
      if (s_int[2] == s_int[1]) int_lvl_q <= s_int[2];
      if (s_c1[2] == s_c1[1]) c1_lvl_q <= s_c1[2];
      if (s_c2[2] == s_c2[1]) c2_lvl_q <= s_c2[2];
    end
  end

  // Source decode: bit2 pin low, bit1 cmp2, bit0 cmp1
  always_comb begin
    src  = sd_q[bpsd_pkg::SD_SRC_LSB +: 3];
    cond = (src[2] & ~int_lvl_q) | (src[1] & c2_lvl_q) | (src[0] & c1_lvl_q);
    full = mc_q[bpsd_pkg::MC_FULL];
    // Software shutdown must stop output even when auto-restart clears the bit at once
    sw_shut = wr & (addr == bpsd_pkg::ADDR_SHUTDOWN_CTRL) & wdata[bpsd_pkg::SD_STATUS];
    pend = full & (mc_q[bpsd_pkg::MC_DIR] != dir_q);
    // Early window: last LEAD_CYCLES of the period, judged from last length
    lead = pend & (plen_q > 8'(bpsd_pkg::LEAD_CYCLES)) &
           (lead_q + 8'(bpsd_pkg::LEAD_CYCLES) >= plen_q);
  end

  // Register file and state next values
  always_comb begin
    mc_d = mc_q; sd_d = sd_q; pc_d = pc_q; dir_d = dir_q; st_d = st_q;
    per_cnt_d = per_cnt_q; flag_d = period_timer_flag;
    lead_d = period_start ? 8'h00 : (lead_q == 8'hff ? lead_q : lead_q + 8'h01);
    plen_d = period_start ? lead_q + 8'h01 : plen_q;
    rdata_d = 8'h00;
    if (rd) begin
      if (addr == bpsd_pkg::ADDR_MODULE_CTRL) rdata_d = mc_q;
      else if (addr == bpsd_pkg::ADDR_SHUTDOWN_CTRL) rdata_d = sd_q;
      else if (addr == bpsd_pkg::ADDR_PWM_CTRL) rdata_d = pc_q;
      else rdata_d = {5'h00, cond, dir_q, st_q == bpsd_pkg::BPSD_RUN};
    end
    if (wr) begin
      if (addr == bpsd_pkg::ADDR_MODULE_CTRL) begin
        mc_d = wdata;
        if (wdata[bpsd_pkg::MC_FULL] & ~full) per_cnt_d = 2'h0;
      end else if (addr == bpsd_pkg::ADDR_SHUTDOWN_CTRL) begin
        sd_d[6:0] = wdata[6:0];
        if (!cond) sd_d[bpsd_pkg::SD_STATUS] = wdata[bpsd_pkg::SD_STATUS];
      end else if (addr == bpsd_pkg::ADDR_PWM_CTRL) begin
        pc_d = wdata;
      end else if (wdata[0]) begin
        flag_d = 1'b0; // Clear period flag
      end
    end
    // Set wins over any clear
    if (cond) sd_d[bpsd_pkg::SD_STATUS] = 1'b1;
    else if (pc_q[bpsd_pkg::PC_RESTART]) sd_d[bpsd_pkg::SD_STATUS] = 1'b0;
    if (period_start) begin
      dir_d = mc_q[bpsd_pkg::MC_DIR];
      if (per_cnt_q != 2'h2) per_cnt_d = per_cnt_q + 2'h1;
      if (per_cnt_q == 2'h1) flag_d = 1'b1;
    end
    case (st_q)
      bpsd_pkg::BPSD_IDLE: if (period_start) st_d = bpsd_pkg::BPSD_RUN;
      bpsd_pkg::BPSD_RUN:  if (sd_d[bpsd_pkg::SD_STATUS] | sw_shut) st_d = bpsd_pkg::BPSD_SHUT;
      bpsd_pkg::BPSD_SHUT: if (!sd_d[bpsd_pkg::SD_STATUS]) st_d = bpsd_pkg::BPSD_IDLE;
      default: st_d = bpsd_pkg::BPSD_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mc_q <= bpsd_pkg::RST_MODULE_CTRL;
      sd_q <= bpsd_pkg::RST_SHUTDOWN_CTRL;
      pc_q <= bpsd_pkg::RST_PWM_CTRL;
      dir_q <= 1'b0; per_cnt_q <= 2'h0; period_timer_flag <= 1'b0;
      lead_q <= 8'h00; plen_q <= 8'h00; rdata <= 8'h00;
      st_q <= bpsd_pkg::BPSD_IDLE;
    end else begin
      mc_q <= mc_d; sd_q <= sd_d; pc_q <= pc_d;
      dir_q <= dir_d; per_cnt_q <= per_cnt_d; period_timer_flag <= flag_d;
      lead_q <= lead_d; plen_q <= plen_d; rdata <= rdata_d;
      st_q <= st_d;
    end
  end

  // Output mapping; shutdown path is combinational from the live level
  // so pins leave normal drive without waiting for a period boundary
  logic [3:0] act;  // Active-high logical levels D,C,B,A
  logic [3:0] pol;  // Per-pin inversion
  logic       shut; // Forced shutdown
  logic       dn;   // Effective direction, reverse = 1
  logic       run;  // Modulation allowed
  always_comb begin
    dn  = lead ? mc_q[bpsd_pkg::MC_DIR] : dir_q;
    run = (st_q == bpsd_pkg::BPSD_RUN) & ~lead & ~pend;
    act = 4'h0;
    if (st_q == bpsd_pkg::BPSD_RUN) begin
      if (full) begin
        // No dead-band: outputs switch on the same edge
        act[0] = ~dn;
        act[2] = dn;
        act[3] = ~dn & run & pwm_mod;
        act[1] = dn & run & pwm_mod;
      end else begin
        act[0] = pwm_mod;
      end
    end
    pol  = {mc_q[bpsd_pkg::MC_POL_BD], mc_q[bpsd_pkg::MC_POL_AC],
            mc_q[bpsd_pkg::MC_POL_BD], mc_q[bpsd_pkg::MC_POL_AC]};
    shut = cond | sd_q[bpsd_pkg::SD_STATUS];
    out_o  = act ^ pol;
    out_oe = 4'hf;
    if (shut) begin
      out_o[0] = sd_q[bpsd_pkg::SD_AC_LSB];
      out_o[2] = sd_q[bpsd_pkg::SD_AC_LSB];
      out_o[1] = sd_q[bpsd_pkg::SD_BD_LSB];
      out_o[3] = sd_q[bpsd_pkg::SD_BD_LSB];
      out_oe[0] = ~sd_q[bpsd_pkg::SD_AC_LSB + 1];
      out_oe[2] = ~sd_q[bpsd_pkg::SD_AC_LSB + 1];
      out_oe[1] = ~sd_q[bpsd_pkg::SD_BD_LSB + 1];
      out_oe[3] = ~sd_q[bpsd_pkg::SD_BD_LSB + 1];
    end
  end

  // Checks beside the logic
  AST_LEVEL_SETS: assert property (@(posedge clk) disable iff (rst)
    cond |=> sd_q[bpsd_pkg::SD_STATUS]) else $error("status not set by level");
  AST_SHUT_PINS: assert property (@(posedge clk) disable iff (rst)
    (cond && sd_q[3:2] == bpsd_pkg::SS_HIGH) |-> out_o[0] && out_o[2]) else $error("pair AC");
  AST_BD_HIZ: assert property (@(posedge clk) disable iff (rst)
    (cond && sd_q[1]) |-> out_oe[1] == 1'b0 && out_oe[3] == 1'b0) else $error("pair BD");
  AST_AUTO_CLR: assert property (@(posedge clk) disable iff (rst)
    (!cond && pc_q[7] && !(wr && addr == 2'h2)) |=> !sd_q[7]) else $error("no auto clear");
  AST_STICKY: assert property (@(posedge clk) disable iff (rst)
    (sd_q[7] && !pc_q[7] && !wr) |=> sd_q[7]) else $error("status lost");
  AST_RESUME: assert property (@(posedge clk) disable iff (rst)
    $fell(st_q == bpsd_pkg::BPSD_SHUT) |-> st_q == bpsd_pkg::BPSD_IDLE) else $error("resume");
  AST_DIR_LATCH: assert property (@(posedge clk) disable iff (rst)
    !$past(period_start) |-> $stable(dir_q)) else $error("direction mid period");
  AST_FWD: assert property (@(posedge clk) disable iff (rst)
    (st_q == bpsd_pkg::BPSD_RUN && full && !dn && !shut) |-> !act[1] && !act[2])
    else $error("forward map");
  AST_REV_GAP: assert property (@(posedge clk) disable iff (rst)
    pend |-> !act[1] && !act[3]) else $error("modulated active in reversal");
endmodule : bpsd_core

// ---- test/bpsd_bridge_model.sv ----
// Bridge switch driver model seen by the output pins
`timescale 1ns/1ps
module bpsd_bridge_model (
  input  wire logic [3:0] drv,    // Pin levels D,C,B,A
  input  wire logic [3:0] drv_oe, // Pin enables D,C,B,A
  output logic      [3:0] gate    // Gate levels seen by switches
);
  // Released pins fall to the pull-down so a switch stays off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate[i] = drv_oe[i] ? drv[i] : 1'b0;
    end
  end
endmodule : bpsd_bridge_model

// ---- test/bpsd_core_bench.sv ----
// Self-checking bench for the bridge output and shutdown block
`timescale 1ns/1ps
module bpsd_core_bench;
  logic       clk, rst, wr, rd, period_start, pwm_mod;  // Clock, strobes, period
  logic       ext_int_pin, cmp1_out, cmp2_out, period_timer_flag; // Trigger levels, flag
  logic [1:0] addr;                                      // Register address
  logic [7:0] wdata, rdata, q;                           // Bus data, read result
  logic [3:0] out_o, out_oe, pins;                       // Pin side
  int         error_cnt, tests_run;                      // Counters
  bpsd_core uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .period_start(period_start), .pwm_mod(pwm_mod), .ext_int_pin(ext_int_pin),
    .cmp1_out(cmp1_out), .cmp2_out(cmp2_out), .out_o(out_o), .out_oe(out_oe),
    .period_timer_flag(period_timer_flag));
  bpsd_bridge_model bridge (.drv(out_o), .drv_oe(out_oe), .gate(pins));
  // Clock of 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task chk(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  // One write cycle on the plain port
  task wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask : wreg
  // Read data stands only in the cycle after the strobe
  task rreg(input logic [1:0] a);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 q = rdata;
  endtask : rreg
  // One-cycle period boundary, then gap cycles
  task pulse(input int gap);
    @(posedge clk); period_start <= 1'b1;
    @(posedge clk); period_start <= 1'b0;
    tick(gap);
  endtask : pulse
  // Reset values, then start-up flag after two periods
  task t_start();
    for (int a = 0; a < 3; a++) begin
      rreg(a[1:0]);
      chk(8'h00, q);
    end
    wreg(2'h0, 8'h40);
    pulse(2);
    chk(8'h00, {7'h0, period_timer_flag});
    pulse(2);
    chk(8'h01, {7'h0, period_timer_flag});
    wreg(2'h3, 8'h01);
    rreg(2'h3);
    chk(8'h01, q);
    chk(8'h00, {7'h0, period_timer_flag});
    $display("Done: start-up");
  endtask : t_start
  // Mid-period reversal; a 17-cycle first period so the end is predictable
  task t_dir();
    @(posedge clk); pwm_mod <= 1'b1;
    pulse(14);
    chk(8'h09, pins);
    @(posedge clk); pwm_mod <= 1'b0;
    pulse(4);
    wreg(2'h0, 8'hc0);
    tick(1);
    chk(8'h01, pins);
    tick(9);
    chk(8'h04, pins);
    @(posedge clk); pwm_mod <= 1'b1;
    pulse(2);
    chk(8'h06, pins);
    wreg(2'h0, 8'hc3);
    pulse(2);
    chk(8'h09, pins);
    @(posedge clk); pwm_mod <= 1'b0;
    wreg(2'h0, 8'h40);
    pulse(2);
    @(posedge clk); pwm_mod <= 1'b1;
    $display("Done: direction");
  endtask : t_dir
  // Every non-zero source code, unselected triggers first, then software restart
  task t_shut();
    logic [7:0] sd;
    for (int c = 1; c < 8; c++) begin
      sd = {1'b0, c[2:0], 4'h4};
      wreg(2'h1, sd);
      @(posedge clk); cmp1_out <= !c[0]; cmp2_out <= !c[1]; ext_int_pin <= c[2];
      tick(6);
      rreg(2'h1);
      chk(sd, q);
      @(posedge clk);
      if (c[0]) cmp1_out <= 1'b1;
      else if (c[1]) cmp2_out <= 1'b1;
      else ext_int_pin <= 1'b0;
      tick(6);
      chk(8'h05, pins);
      wreg(2'h1, sd);
      rreg(2'h1);
      chk({1'b1, sd[6:0]}, q);
      @(posedge clk); cmp1_out <= 1'b0; cmp2_out <= 1'b0; ext_int_pin <= 1'b1;
      tick(6);
      chk(8'h05, pins);
      wreg(2'h1, sd);
      tick(1);
      chk(8'h00, pins);
      pulse(2);
      chk(8'h09, pins);
    end
    wreg(2'h1, 8'h19);
    @(posedge clk); cmp1_out <= 1'b1;
    tick(6);
    chk(8'h0a, out_oe);
    chk(8'h0a, pins);
    @(posedge clk); cmp1_out <= 1'b0;
    tick(6);
    wreg(2'h1, 8'h00);
    $display("Done: shutdown");
  endtask : t_shut
  // Auto-restart after software and comparator shutdown
  task t_auto();
    pulse(2);
    wreg(2'h2, 8'h80);
    wreg(2'h1, 8'h94);
    tick(1);
    chk(8'h00, pins);
    rreg(2'h1);
    chk(8'h14, q);
    @(posedge clk); cmp1_out <= 1'b1;
    tick(6);
    rreg(2'h1);
    chk(8'h94, q);
    @(posedge clk); cmp1_out <= 1'b0;
    tick(6);
    rreg(2'h1);
    chk(8'h14, q);
    pulse(2);
    chk(8'h09, pins);
    $display("Done: auto-restart");
  endtask : t_auto
  task finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // Watchdog well beyond the expected run
  initial begin
    #200us;
    error_cnt++;
    finish_test();
  end
  // Main sequence
  initial begin
    {rst, wr, rd, period_start, pwm_mod, cmp1_out, cmp2_out} = '0;
    {ext_int_pin, addr, wdata, error_cnt, tests_run} = '0;
    ext_int_pin = 1'b1;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_start();
    t_dir();
    t_shut();
    t_auto();
    finish_test();
  end
endmodule : bpsd_core_bench
